// ### rtl/aspm_pkg.sv
package aspm_pkg;

  // ----------------------------------------------------------------
  // Geometry
  // ----------------------------------------------------------------
  localparam int NUM_PORTS = 6;
  localparam int DELAY_W = 16;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam longint CLK_HZ = 25000000;
  localparam longint ACTIVITY_MIN_MS = 200;
  localparam longint EXPANDER_PERIOD_MS = 40;
  localparam int ACTIVITY_PERIODS = 5;
  localparam longint ACTIVITY_HOLD_CYCLES = (ACTIVITY_MIN_MS * CLK_HZ + 999) / 1000;
  localparam longint EXPANDER_PERIOD_CYCLES = (EXPANDER_PERIOD_MS * CLK_HZ) / 1000;

  // ----------------------------------------------------------------
  // Register map (word aligned byte offsets)
  // ----------------------------------------------------------------
  localparam logic [7:0] LINK_CONTROL_OFFS = 8'h00;
  localparam logic [7:0] PM_PRIVATE_CONTROL_OFFS = 8'h04;
  localparam logic [7:0] LINK_STATUS_OFFS = 8'h08;
  localparam logic [7:0] PM_STATE_OFFS = 8'h0C;

  // Link control fields: bit 0 enables L0s, bit 1 enables L1
  localparam int ASPM_L0S_BIT = 0;
  localparam int ASPM_L1_BIT = 1;
  localparam logic [1:0] LINK_CONTROL_RESET = 2'h0;

  // Private control: l0s_entry_delay [15:0], l1_entry_delay [31:16]
  localparam int L0S_DELAY_LSB = 0;
  localparam int L1_DELAY_LSB = 16;
  localparam logic [15:0] L0S_DELAY_RESET = 16'h0100;
  localparam logic [15:0] L1_DELAY_RESET = 16'h1000;

  // Link training state as seen by this block
  typedef enum logic [2:0] {
    LTSSM_DOWN = 3'h0,
    LTSSM_L0 = 3'h1,
    LTSSM_L0S = 3'h2,
    LTSSM_L1 = 3'h3,
    LTSSM_RECOVERY = 3'h4
  } ltssm_t;

  // Per-port status from the port's link and transaction layers
  typedef struct packed {
    ltssm_t ltssm;
    logic rx_in_l0s;
    logic in_d3;
    logic tlp_pending;
    logic fc_credit_ok;
    logic dllp_pending;
    logic tlp_seen;
    logic tlp_is_vendor_msg;
  } port_status_t;

  // Per-port transmit power requests toward the link layer
  typedef struct packed {
    logic enter_l0s;
    logic exit_l0s;
    logic req_l1;
  } port_pm_req_t;

endpackage

// ### rtl/link_active_power_and_status.sv
// Behaviour
// RL1: with link control enabled, hardware alone makes all low-power link transitions.
// RL2: both L0s and the optional L1 state are supported.
// RL3: L0s entry only after its conditions held for the l0s_entry_delay count.
// RL4: upstream L0s needs receive L0s on every active, non-D3 downstream port.
// RL5: upstream L0s needs no upstream TLP queued, or no credits to send.
// RL6: upstream L0s needs no DLLP pending upstream.
// RL7: downstream L0s needs upstream receive lanes in L0s.
// RL8: downstream L0s needs no TLP queued there, or no credits to send.
// RL9: downstream L0s needs no DLLP pending on that port.
// RL10: L1 request only after its conditions held for the l1_entry_delay count.
// RL11: met L1 conditions while in L0 or L0s send an L1 request.
// RL12: only the upstream port requests L1; downstream ports never do.
// RL13: partner acks or rejects L1; ack enters L1, reject enters L0s. Here a reject only pulses l1_reject_l0s; enter_l0s is not raised.
// RL14: upstream requests L1 only when all active, non-D3 downstream ports are in L1.
// RL15: each port gives link-up and activity status, sent over expander 4.
// RL16: link-up set in L0, L0s, L1 or Recovery; cleared when link down.
// RL17: activity set by any TLP sent or received, except vendor messages.
// RL18: activity stays set at least 200 ms, retriggered by more traffic.
// RL19: expander outputs change at most once per 40 ms, five periods.
// RL20: an entry delay counter restarts at zero when any condition drops.
// RL21: a port in L0s starts transmit exit once a TLP or DLLP is pending.
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/10ps
`default_nettype none

module link_active_power_and_status #(
  parameter int NUM_PORTS = aspm_pkg::NUM_PORTS,
  parameter longint ACTIVITY_HOLD_CYCLES = aspm_pkg::ACTIVITY_HOLD_CYCLES,
  parameter longint EXPANDER_PERIOD_CYCLES = aspm_pkg::EXPANDER_PERIOD_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone classic slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Port 0 is the upstream port
  input wire aspm_pkg::port_status_t [NUM_PORTS-1:0] port_status_i,
  input wire logic l1_ack_i,
  input wire logic l1_reject_i,
  output aspm_pkg::port_pm_req_t [NUM_PORTS-1:0] pm_req_o,
  output logic [NUM_PORTS-1:0] port_link_up_out_o,
  output logic [NUM_PORTS-1:0] port_activity_out_o,
  output logic expander_update_o
);
  import aspm_pkg::*;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [1:0] link_control_reg;
  logic [31:0] pm_private_control_reg;
  logic [15:0] l0s_entry_delay;
  logic [15:0] l1_entry_delay;
  logic wb_hit;
  logic [31:0] next_dat;

  assign l0s_entry_delay = pm_private_control_reg[L0S_DELAY_LSB +: DELAY_W];
  assign l1_entry_delay = pm_private_control_reg[L1_DELAY_LSB +: DELAY_W];
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;

  // Register writes, byte lanes honoured; only taken on the ack edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      link_control_reg <= LINK_CONTROL_RESET;
      pm_private_control_reg <= {L1_DELAY_RESET, L0S_DELAY_RESET};
    end else if (wb_hit && wb_we_i) begin
      if (wb_adr_i == LINK_CONTROL_OFFS && wb_sel_i[0]) begin
        link_control_reg <= wb_dat_i[1:0]; // RL1
      end
      if (wb_adr_i == PM_PRIVATE_CONTROL_OFFS) begin
        for (int b = 0; b < 4; b++) begin
          if (wb_sel_i[b]) begin
            pm_private_control_reg[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Per-port conditions
  // ----------------------------------------------------------------
  logic [NUM_PORTS-1:0] port_active;
  logic [NUM_PORTS-1:0] in_l0s;
  logic [NUM_PORTS-1:0] in_l1;
  logic [NUM_PORTS-1:0] tx_idle;
  logic [NUM_PORTS-1:0] l0s_cond;
  logic [NUM_PORTS-1:0] in_l1_state;
  logic down_rx_l0s;
  logic down_all_l1;
  logic l1_cond;

  // Ports in D3 or with the link down are left out of the checks
  always_comb begin
    down_rx_l0s = 1'b1;
    down_all_l1 = 1'b1;
    for (int p = 1; p < NUM_PORTS; p++) begin
      if (port_active[p] && !port_status_i[p].rx_in_l0s) begin
        down_rx_l0s = 1'b0; // RL4
      end
      if (port_active[p] && port_status_i[p].ltssm != LTSSM_L1) begin
        down_all_l1 = 1'b0; // RL14
      end
    end
  end

  genvar g;
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_cond
      assign port_active[g] = !port_status_i[g].in_d3 && port_status_i[g].ltssm != LTSSM_DOWN;
      assign in_l0s[g] = port_status_i[g].ltssm == LTSSM_L0S;
      assign in_l1[g] = port_status_i[g].ltssm == LTSSM_L1;
      // No TLP to send, or no credit to send it; no DLLP waiting
      assign tx_idle[g] = (!port_status_i[g].tlp_pending || !port_status_i[g].fc_credit_ok)
                          && !port_status_i[g].dllp_pending; // RL5 RL6 RL8 RL9
      if (g == 0) begin : g_up
        assign l0s_cond[g] = down_rx_l0s && tx_idle[g]; // RL4 RL5 RL6
      end else begin : g_down
        assign l0s_cond[g] = port_status_i[0].rx_in_l0s && tx_idle[g]; // RL7 RL8 RL9
      end
      assign in_l1_state[g] = in_l1[g];
    end
  endgenerate

  // L1 request conditions apply to the upstream port alone
  assign l1_cond = down_all_l1 && tx_idle[0]
                   && (port_status_i[0].ltssm == LTSSM_L0 || in_l0s[0]); // RL11 RL14

  // ----------------------------------------------------------------
  // L0s entry timers and transmit requests, one per port
  // ----------------------------------------------------------------
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_l0s
      logic [DELAY_W-1:0] l0s_cnt;
      logic l0s_armed;
      logic tx_work;
      assign tx_work = port_status_i[g].tlp_pending || port_status_i[g].dllp_pending;

      // Counter restarts whenever any condition falls away
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          l0s_cnt <= '0;
          l0s_armed <= 1'b0;
        end else if (!link_control_reg[ASPM_L0S_BIT] || !l0s_cond[g]
                     || port_status_i[g].ltssm != LTSSM_L0) begin
          l0s_cnt <= '0; // RL20
          l0s_armed <= 1'b0;
        end else if (l0s_cnt >= l0s_entry_delay) begin
          l0s_armed <= 1'b1; // RL3
        end else begin
          l0s_cnt <= l0s_cnt + 1'b1;
        end
      end

      // Entry and exit strobes, set independently; both can be high in the same cycle
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pm_req_o[g].enter_l0s <= 1'b0;
          pm_req_o[g].exit_l0s <= 1'b0;
        end else begin
          pm_req_o[g].exit_l0s <= in_l0s[g] && tx_work; // RL21
          pm_req_o[g].enter_l0s <= l0s_armed && l0s_cond[g]
                                   && link_control_reg[ASPM_L0S_BIT]; // RL1 RL2 RL3
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // L1 request, upstream port only
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    L1_IDLE = 3'b001,
    L1_WAIT = 3'b010,
    L1_REQ = 3'b100
  } l1_state_t;

  l1_state_t l1_state;
  logic [DELAY_W-1:0] l1_cnt;
  logic l1_reject_l0s;

  // Timer, request and partner answer
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      l1_state <= L1_IDLE;
      l1_cnt <= '0;
      l1_reject_l0s <= 1'b0;
    end else begin
      l1_reject_l0s <= 1'b0;
      case (l1_state)
        L1_IDLE: begin
          l1_cnt <= '0;
          if (link_control_reg[ASPM_L1_BIT] && l1_cond) begin
            l1_state <= L1_WAIT;
          end
        end
        L1_WAIT: begin
          if (!link_control_reg[ASPM_L1_BIT] || !l1_cond) begin
            l1_state <= L1_IDLE; // RL20
            l1_cnt <= '0;
          end else if (l1_cnt >= l1_entry_delay) begin
            l1_state <= L1_REQ; // RL10 RL11
          end else begin
            l1_cnt <= l1_cnt + 1'b1;
          end
        end
        L1_REQ: begin
          // Held until the partner answers; ack takes the link to L1
          if (l1_ack_i) begin
            l1_state <= L1_IDLE; // RL13
          end else if (l1_reject_i) begin
            l1_state <= L1_IDLE;
            l1_reject_l0s <= 1'b1; // RL13
          end
        end
        default: l1_state <= L1_IDLE;
      endcase
    end
  end

  // Request level on port 0; downstream ports tied off in the register
  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_l1req
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          pm_req_o[g].req_l1 <= 1'b0;
        end else if (g == 0) begin
          pm_req_o[g].req_l1 <= (l1_state == L1_REQ) && !l1_ack_i && !l1_reject_i; // RL11
        end else begin
          pm_req_o[g].req_l1 <= 1'b0; // RL12
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Link status and activity, paced by the expander period
  // ----------------------------------------------------------------
  logic [31:0] period_cnt;
  logic period_tick;
  logic [NUM_PORTS-1:0] link_up_now;
  logic [NUM_PORTS-1:0] activity_now;

  assign period_tick = period_cnt == 32'(EXPANDER_PERIOD_CYCLES - 1);

  // Update period divider; outputs may change only on its tick
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      period_cnt <= '0;
      expander_update_o <= 1'b0;
    end else begin
      period_cnt <= period_tick ? 32'h0 : period_cnt + 32'h1;
      expander_update_o <= period_tick; // RL15 RL19
    end
  end

  generate
    for (g = 0; g < NUM_PORTS; g++) begin : g_stat
      logic [31:0] hold_cnt;
      assign link_up_now[g] = port_status_i[g].ltssm != LTSSM_DOWN; // RL16
      assign activity_now[g] = hold_cnt != 32'h0;

      // Hold counter reloads on every qualifying TLP
      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          hold_cnt <= '0;
        end else if (port_status_i[g].tlp_seen && !port_status_i[g].tlp_is_vendor_msg) begin
          hold_cnt <= 32'(ACTIVITY_HOLD_CYCLES); // RL17 RL18
        end else if (hold_cnt != 32'h0) begin
          hold_cnt <= hold_cnt - 32'h1;
        end
      end
    end
  endgenerate

  // Sampling on the tick keeps a pulse across the whole hold window
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      port_link_up_out_o <= '0;
      port_activity_out_o <= '0;
    end else if (period_tick) begin
      port_link_up_out_o <= link_up_now; // RL16 RL19
      port_activity_out_o <= activity_now; // RL18 RL19
    end
  end

  // ----------------------------------------------------------------
  // Wishbone read data and ack, one wait-free cycle
  // ----------------------------------------------------------------
  always_comb begin
    next_dat = 32'h0;
    case (wb_adr_i)
      LINK_CONTROL_OFFS: next_dat = {30'h0, link_control_reg};
      PM_PRIVATE_CONTROL_OFFS: next_dat = pm_private_control_reg;
      LINK_STATUS_OFFS: next_dat = {16'h0, 8'(port_activity_out_o), 8'(port_link_up_out_o)};
      PM_STATE_OFFS: next_dat = {21'h0, l1_reject_l0s, 7'(in_l1_state), l1_state};
      default: next_dat = 32'h0;
    endcase
  end

  // Unmapped reads return zero, unmapped writes are acked and dropped
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= wb_hit ? next_dat : 32'h0;
    end
  end

endmodule

`default_nettype wire

// ### testbench/lps_assertions.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Port-level checks
// ----------------------------------------
module lps_checker
  import aspm_pkg::*;
#(
  parameter int NUM_PORTS = 6,
  parameter longint ACTIVITY_HOLD_CYCLES = 50,
  parameter longint EXPANDER_PERIOD_CYCLES = 10
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire port_status_t [NUM_PORTS-1:0] port_status_i,
  input wire logic l1_ack_i,
  input wire logic l1_reject_i,
  input wire port_pm_req_t [NUM_PORTS-1:0] pm_req_o,
  input wire logic [NUM_PORTS-1:0] port_link_up_out_o,
  input wire logic [NUM_PORTS-1:0] port_activity_out_o,
  input wire logic expander_update_o
);
  logic dn_l1;
  logic dn_ready;
  logic dn_cond;

  // Downstream summary; D3 and dead links do not hold up L1
  always_comb begin
    dn_l1 = 1'b0;
    dn_ready = 1'b1;
    for (int p = 1; p < NUM_PORTS; p++) begin
      dn_l1 = dn_l1 | pm_req_o[p].req_l1;
      if (!port_status_i[p].in_d3 && port_status_i[p].ltssm != LTSSM_DOWN &&
          port_status_i[p].ltssm != LTSSM_L1) begin
        dn_ready = 1'b0;
      end
    end
  end

  // Port 1 entry condition, checked three edges back to allow for the arm stage
  assign dn_cond = port_status_i[0].rx_in_l0s && !port_status_i[1].dllp_pending &&
      (!port_status_i[1].tlp_pending || !port_status_i[1].fc_credit_ok);

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_ack_after_req: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");
  a_l1_dn_never: assert property (!dn_l1)
    else $error("downstream port requested L1");
  a_l1_req_holds: assert property (pm_req_o[0].req_l1 && !l1_ack_i && !l1_reject_i |=> pm_req_o[0].req_l1)
    else $error("L1 request dropped without answer");
  a_l1_req_drops: assert property (pm_req_o[0].req_l1 && (l1_ack_i || l1_reject_i) |=> !pm_req_o[0].req_l1)
    else $error("L1 request stayed after answer");
  a_l1_needs_dn: assert property ($rose(pm_req_o[0].req_l1) |-> $past(dn_ready))
    else $error("L1 requested with downstream port awake");
  a_tick_spacing: assert property (expander_update_o |=> !expander_update_o [*8])
    else $error("expander updates too close");
  a_status_on_tick: assert property ($changed({port_link_up_out_o, port_activity_out_o}) |-> expander_update_o || $past(expander_update_o))
    else $error("status changed between expander updates");
  a_dn_l0s_guard: assert property ($rose(pm_req_o[1].enter_l0s) |-> $past(dn_cond, 3))
    else $error("downstream L0s entered without its conditions");

  c_l1_reject: cover property (pm_req_o[0].req_l1 && l1_reject_i);
  c_l1_ack: cover property (pm_req_o[0].req_l1 && l1_ack_i);
  c_dn_l0s: cover property ($rose(pm_req_o[1].enter_l0s));
endmodule

bind link_active_power_and_status lps_checker #(.NUM_PORTS(NUM_PORTS),
  .ACTIVITY_HOLD_CYCLES(ACTIVITY_HOLD_CYCLES),
  .EXPANDER_PERIOD_CYCLES(EXPANDER_PERIOD_CYCLES)) checker_i (.clk_i, .rst_i, .wb_cyc_i,
  .wb_stb_i, .wb_ack_o, .port_status_i, .l1_ack_i, .l1_reject_i, .pm_req_o,
  .port_link_up_out_o, .port_activity_out_o, .expander_update_o);
`default_nettype wire

// ### testbench/link_partner_model.sv
`timescale 1ns/10ps
`default_nettype none

// ----------------------------------------
// Upstream link partner
// ----------------------------------------
module link_partner_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic l1_req_i,
  input wire logic refuse_i,
  input wire logic [3:0] wait_i,
  output logic l1_ack_o,
  output logic l1_reject_o
);
  logic [3:0] cnt;
  logic done;

  // One answer per request; wait_i plays a slow partner
  always_ff @(posedge clk_i) begin
    l1_ack_o <= 1'b0;
    l1_reject_o <= 1'b0;
    if (rst_i || !l1_req_i) begin
      cnt <= 4'h0;
      done <= 1'b0;
    end else if (!done && cnt == wait_i) begin
      l1_ack_o <= !refuse_i;
      l1_reject_o <= refuse_i;
      done <= 1'b1;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
endmodule
`default_nettype wire

// ### testbench/testbench.sv
`timescale 1ns/10ps
`default_nettype none

module testbench;
  import aspm_pkg::*;
  // Short counts keep the run brief
  localparam int HOLD = 50;
  localparam int PER = 10;
  logic clk_i, rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, l1_ack_i, l1_reject_i;
  logic refuse, tick;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i, lat;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [5:0] up, act;
  port_status_t [5:0] ps;
  port_pm_req_t [5:0] req;
  logic [31:0] model [logic [7:0]];
  int n_mismatch, checks, cycles, n, v, seed;

  link_active_power_and_status #(.NUM_PORTS(6), .ACTIVITY_HOLD_CYCLES(HOLD),
    .EXPANDER_PERIOD_CYCLES(PER)) dut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .port_status_i(ps), .l1_ack_i,
    .l1_reject_i, .pm_req_o(req), .port_link_up_out_o(up), .port_activity_out_o(act),
    .expander_update_o(tick));
  link_partner_model peer (.clk_i, .rst_i, .l1_req_i(req[0].req_l1), .refuse_i(refuse),
    .wait_i(lat), .l1_ack_o(l1_ack_i), .l1_reject_o(l1_reject_i));

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  task automatic give_verdict();
    $display("checks %0d n_mismatch %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // A hung handshake must not stall the run
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 3000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic cycle; reads compare against the register model
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (we && a <= 8'h0C) model[a] = d;
    if (!we) chk(wb_dat_o, model.exists(a) ? model[a] : 32'h0);
    @(posedge clk_i);
  endtask

  function automatic logic pick(input int w);
    return w == 0 ? req[1].enter_l0s : w == 1 ? req[0].req_l1 : act[2];
  endfunction

  task automatic await(input int w, input logic val);
    n = 0;
    while (pick(w) !== val && n < 120) begin
      @(posedge clk_i);
      n++;
    end
  endtask

  task automatic tlp(input logic vendor);
    ps[2].tlp_is_vendor_msg <= vendor;
    ps[2].tlp_seen <= 1'b1;
    @(posedge clk_i);
    ps[2].tlp_seen <= 1'b0;
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    seed = 32'hb2eeca94;
    rst_i = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, refuse} = 4'h1;
    {wb_adr_i, wb_dat_i, ps, lat} = '0;
    wb_sel_i = 4'hF;
    for (int p = 0; p < 6; p++) ps[p].ltssm = LTSSM_L0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    model[8'h00] = 32'h0;
    model[8'h04] = 32'h10000100;
    wb(1'b0, 8'h00, 32'h0);
    wb(1'b0, 8'h04, 32'h0);
    wb(1'b1, 8'h10, 32'hFFFFFFFF);
    wb(1'b0, 8'h10, 32'h0);
    wb(1'b1, 8'h04, 32'h00060004);
    wb(1'b1, 8'h00, 32'h3);
    wb(1'b0, 8'h04, 32'h0);
    wb(1'b0, 8'h00, 32'h0);
    // Random link states; link-up follows on the expander updates
    v = 0;
    for (int p = 0; p < 6; p++) begin
      n = {$random(seed)} % 5;
      ps[p].ltssm <= ltssm_t'(n[2:0]);
      v[p] = n != 0;
    end
    repeat (2 * PER + 2) @(posedge clk_i);
    chk(up, v[5:0]);
    for (int p = 0; p < 6; p++) ps[p].ltssm <= LTSSM_L0;
    repeat (10) @(posedge clk_i);
    chk(req[1].enter_l0s, 1'b0);
    v = $random(seed);
    ps[1].tlp_pending <= v[0];
    ps[1].fc_credit_ok <= ~v[0];
    ps[0].rx_in_l0s <= 1'b1;
    repeat (3) @(posedge clk_i);
    ps[1].dllp_pending <= 1'b1;
    @(posedge clk_i);
    ps[1].dllp_pending <= 1'b0;
    await(0, 1'b1);
    chk(32'(n inside {[7:8]}), 32'h1);
    ps[1].ltssm <= LTSSM_L0S;
    ps[1].dllp_pending <= 1'b1;
    repeat (3) @(posedge clk_i);
    chk(req[1].exit_l0s, 1'b1);
    ps[1].dllp_pending <= 1'b0;
    // L1: port 5 awake first, then every live downstream port asleep
    ps[1].ltssm <= LTSSM_L1;
    ps[2].in_d3 <= 1'b1;
    ps[3].ltssm <= LTSSM_DOWN;
    ps[4].ltssm <= LTSSM_L1;
    repeat (30) @(posedge clk_i);
    chk(req[0].req_l1, 1'b0);
    ps[5].ltssm <= LTSSM_L1;
    await(1, 1'b1);
    chk(32'(n inside {[6:12]}), 32'h1);
    await(1, 1'b0);
    refuse <= 1'b0;
    lat <= 4'h5;
    await(1, 1'b1);
    chk(req[0].req_l1, 1'b1);
    await(1, 1'b0);
    chk(32'(n inside {[5:8]}), 32'h1);
    // Activity: vendor message ignored, retrigger stretches the hold
    tlp(1'b1);
    repeat (3 * PER) @(posedge clk_i);
    chk(act, 6'h0);
    tlp(1'b0);
    await(2, 1'b1);
    chk(32'(n <= 2 * PER), 32'h1);
    repeat (30) @(posedge clk_i);
    tlp(1'b0);
    await(2, 1'b0);
    chk(32'(n + 31 inside {[HOLD + 30:HOLD + 50]}), 32'h1);
    // Expander update spacing, one period between ticks
    @(posedge clk_i iff tick === 1'b1);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (tick !== 1'b1);
    chk(n, PER);
    give_verdict();
  end
endmodule
`default_nettype wire
